// ==== rtl/ltm_mirror.sv ====
// Link test request mirror: auxiliary listener registers and bus target.
// ==========================================================================
// ==========================================================================
`timescale 1ns/10ps
`default_nettype none

module ltm_mirror (
   // Clock, reset and enable.
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   input  wire logic                  clk_en,
   // Observed auxiliary channel traffic from the listener front end.
   input  wire ltm_pkg::ltm_aux_obs_s aux_obs,
   // Management-bus pins and address select strap.
   input  wire logic                  smb_clk_pin,
   input  wire logic                  smb_data_in,
   output var  logic                  smb_data_out,
   output var  logic                  smb_data_oe,
   input  wire logic                  smb_addr_sel,
   // Mirrored state for the redriver datapath.
   output var  logic [7:0]            service_irq_vector,
   output var  ltm_pkg::ltm_lane_adj_s [3:0] lane_adj_req,
   output var  logic [7:0]            sink_test_request,
   output var  logic [7:0]            test_rate_code,
   output var  logic                  test_rate_known
);

   // ==========================================================================
   // Decoding helpers
   // ==========================================================================
   // Reserved test request encodings are masked by configuration version.
   function automatic logic [7:0] treq_mask(input logic [7:0] rev);
      if (rev >= ltm_pkg::CONFIG_REV_V11) begin
         treq_mask = ltm_pkg::TREQ_MASK_V11;
      end else begin
         treq_mask = ltm_pkg::TREQ_MASK_V10;
      end
   endfunction : treq_mask

   // Only the three documented rate codes are known rates.
   function automatic logic rate_is_known(input logic [7:0] code);
      rate_is_known = (code == ltm_pkg::RATE_1G62) ||
                      (code == ltm_pkg::RATE_2G70) ||
                      (code == ltm_pkg::RATE_5G40);
   endfunction : rate_is_known

   // ==========================================================================
   // Pin conditioning
   // ==========================================================================
   logic [2:0] pins_filt;
   logic       scl_f;
   logic       sda_f;
   logic       sel_f;
   logic       scl_prev_q;
   logic       sda_prev_q;

   ltm_pin_filter #(
      .WIDTH(3)
   ) u_pins (
      .core_clk(core_clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .pin_raw ({smb_addr_sel, smb_data_in, smb_clk_pin}),
      .pin_filt(pins_filt)
   );

   assign scl_f = pins_filt[0];
   assign sda_f = pins_filt[1];
   assign sel_f = pins_filt[2];

   // Previous filtered levels for edge and condition detection.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else if (clk_en) begin
         scl_prev_q <= scl_f;
         sda_prev_q <= sda_f;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   // Start and stop are data edges while the clock stays high.
   assign scl_rise  = scl_f && !scl_prev_q;
   assign scl_fall  = !scl_f && scl_prev_q;
   assign bus_start = scl_f && scl_prev_q && !sda_f && sda_prev_q;
   assign bus_stop  = scl_f && scl_prev_q && sda_f && !sda_prev_q;

   // ==========================================================================
   // Auxiliary listener mirror
   // ==========================================================================
   logic [7:0] config_rev_q;
   logic [7:0] test_param_q;
   logic       sink_reply;
   logic       src_write;

   assign sink_reply = aux_obs.valid && !aux_obs.src_write;
   assign src_write  = aux_obs.valid && aux_obs.src_write;

   // Configuration revision decides which test request bits are live.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         config_rev_q <= ltm_pkg::REG_RESET;
      end else if (clk_en && sink_reply &&
                   aux_obs.addr == ltm_pkg::AUX_CONFIG_REV) begin
         config_rev_q <= aux_obs.data;
      end
   end

   // Service vector: sink content sets it, source writes of one clear it.
   // Both come through one observation port, so a set and a clear never
   // land in the same cycle.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         service_irq_vector <= ltm_pkg::REG_RESET;
      end else if (clk_en && aux_obs.addr == ltm_pkg::AUX_IRQ_VECTOR) begin
         if (sink_reply) begin
            // Bits 0, 1, 2, 3 and 6 follow the sink; the rest stay zero.
            service_irq_vector <= aux_obs.data &
                                  ltm_pkg::IRQ_DEFINED_MASK;
         end else if (src_write) begin
            service_irq_vector <= service_irq_vector & ~aux_obs.data;
         end
      end
   end

   // Adjust requests: one nibble per lane, swing low, pre-emphasis high.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lane_adj_req <= '0;
      end else if (clk_en && sink_reply) begin
         if (aux_obs.addr == ltm_pkg::AUX_ADJ_LANES01) begin
            lane_adj_req[1:0] <= aux_obs.data;
         end else if (aux_obs.addr == ltm_pkg::AUX_ADJ_LANES23) begin
            lane_adj_req[3:2] <= aux_obs.data;
         end
      end
   end

   // Test request, rate code and the parameter byte at test_param_220.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sink_test_request <= ltm_pkg::REG_RESET;
         test_rate_code    <= ltm_pkg::REG_RESET;
         test_param_q      <= ltm_pkg::REG_RESET;
         test_rate_known   <= 1'b0;
      end else if (clk_en && sink_reply) begin
         if (aux_obs.addr == ltm_pkg::AUX_TEST_REQUEST) begin
            // Only training, pattern, identification read and, under 1.1,
            // PHY pattern survive; everything else reads zero.
            sink_test_request <= aux_obs.data &
                                 treq_mask(config_rev_q);
         end else if (aux_obs.addr == ltm_pkg::AUX_TEST_RATE) begin
            test_rate_code  <= aux_obs.data;
            test_rate_known <= rate_is_known(aux_obs.data);
         end else if (aux_obs.addr == ltm_pkg::AUX_TEST_PARAM_220) begin
            test_param_q <= aux_obs.data;
         end
      end
   end

   // ==========================================================================
   // Register read mux by bus index
   // ==========================================================================
   logic [7:0] idx_q;
   logic [7:0] rd_byte;

   // Indexes outside the bank read zero.
   always_comb begin
      rd_byte = ltm_pkg::REG_RESET;
      if (idx_q == ltm_pkg::IDX_IRQ_VECTOR) begin
         rd_byte = service_irq_vector;
      end else if (idx_q == ltm_pkg::IDX_ADJ_LANES01) begin
         rd_byte = lane_adj_req[1:0];
      end else if (idx_q == ltm_pkg::IDX_ADJ_LANES23) begin
         rd_byte = lane_adj_req[3:2];
      end else if (idx_q == ltm_pkg::IDX_TEST_REQUEST) begin
         rd_byte = sink_test_request;
      end else if (idx_q == ltm_pkg::IDX_TEST_RATE) begin
         rd_byte = test_rate_code;
      end else if (idx_q == ltm_pkg::IDX_TEST_PARAM_220) begin
         rd_byte = test_param_q;
      end
   end

   // ==========================================================================
   // Management-bus target
   // ==========================================================================
   ltm_pkg::ltm_bus_state_e state_q;
   logic [7:0]              shift_q;
   logic [3:0]              bit_cnt_q;
   logic [7:0]              wr_cnt_q;
   logic                    rd_dir_q;
   logic                    rd_first_q;
   logic                    master_ack_q;
   logic                    addr_hit;
   logic [7:0]              remain;

   // The low target address bit follows the filtered select strap.
   assign addr_hit = shift_q[7:1] ==
                     {ltm_pkg::TARGET_ADDR_BASE[6:1], sel_f};
   assign remain = (idx_q < ltm_pkg::IDX_COUNT) ?
                   8'(ltm_pkg::IDX_COUNT - idx_q) : 8'h00;

   // Byte framing: bits are sampled on clock rise, the data line changes
   // only on clock fall, so the target never makes a false start or stop.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q      <= ltm_pkg::ST_IDLE;
         shift_q      <= 8'h00;
         bit_cnt_q    <= 4'h0;
         wr_cnt_q     <= 8'h00;
         rd_dir_q     <= 1'b0;
         rd_first_q   <= 1'b0;
         master_ack_q <= 1'b0;
         idx_q        <= 8'h00;
         smb_data_out <= 1'b1;
         smb_data_oe  <= 1'b0;
      end else if (clk_en) begin
         if (bus_stop) begin
            state_q     <= ltm_pkg::ST_IDLE;
            smb_data_oe <= 1'b0;
         end else if (bus_start) begin
            // A repeated start keeps the index for the indexed read.
            state_q     <= ltm_pkg::ST_ADDR;
            bit_cnt_q   <= 4'h0;
            smb_data_oe <= 1'b0;
         end else if (scl_rise) begin
            case (state_q)
               ltm_pkg::ST_ADDR, ltm_pkg::ST_WBYTE: begin
                  shift_q   <= {shift_q[6:0], sda_f};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
               ltm_pkg::ST_RBYTE: begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
               ltm_pkg::ST_RBYTE_ACK: begin
                  master_ack_q <= !sda_f;
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (state_q)
               ltm_pkg::ST_ADDR: begin
                  if (bit_cnt_q == ltm_pkg::BITS_PER_BYTE) begin
                     if (addr_hit) begin
                        state_q      <= ltm_pkg::ST_ADDR_ACK;
                        rd_dir_q     <= shift_q[0];
                        smb_data_out <= 1'b0;
                        smb_data_oe  <= 1'b1;
                     end else begin
                        state_q <= ltm_pkg::ST_IDLE;
                     end
                  end
               end
               ltm_pkg::ST_ADDR_ACK: begin
                  bit_cnt_q <= 4'h0;
                  wr_cnt_q  <= 8'h00;
                  if (rd_dir_q) begin
                     // A block read opens with its byte count.
                     state_q      <= ltm_pkg::ST_RBYTE;
                     rd_first_q   <= 1'b1;
                     shift_q      <= remain;
                     smb_data_out <= remain[7];
                     smb_data_oe  <= 1'b1;
                  end else begin
                     state_q     <= ltm_pkg::ST_WBYTE;
                     smb_data_oe <= 1'b0;
                  end
               end
               ltm_pkg::ST_WBYTE: begin
                  if (bit_cnt_q == ltm_pkg::BITS_PER_BYTE) begin
                     state_q      <= ltm_pkg::ST_WBYTE_ACK;
                     smb_data_out <= 1'b0;
                     smb_data_oe  <= 1'b1;
                     // First byte is the command code, i.e. the index.
                     // The count byte is skipped, data bytes only advance the index: the
                     // mirror is owned by the listener, so bus writes never
                     // alter it, and a lone byte after the command has no
                     // effect at all.
                     if (wr_cnt_q == 8'h00) begin
                        idx_q <= shift_q;
                     end else if (wr_cnt_q != 8'h01) begin
                        idx_q <= idx_q + 8'h01;
                     end
                     if (wr_cnt_q != 8'hFF) begin
                        wr_cnt_q <= wr_cnt_q + 8'h01;
                     end
                  end
               end
               ltm_pkg::ST_WBYTE_ACK: begin
                  state_q     <= ltm_pkg::ST_WBYTE;
                  bit_cnt_q   <= 4'h0;
                  smb_data_oe <= 1'b0;
               end
               ltm_pkg::ST_RBYTE: begin
                  if (bit_cnt_q == ltm_pkg::BITS_PER_BYTE) begin
                     state_q     <= ltm_pkg::ST_RBYTE_ACK;
                     smb_data_oe <= 1'b0;
                     if (!rd_first_q) begin
                        idx_q <= idx_q + 8'h01;
                     end
                  end else begin
                     shift_q      <= {shift_q[6:0], 1'b0};
                     smb_data_out <= shift_q[6];
                  end
               end
               ltm_pkg::ST_RBYTE_ACK: begin
                  bit_cnt_q  <= 4'h0;
                  rd_first_q <= 1'b0;
                  if (master_ack_q) begin
                     state_q      <= ltm_pkg::ST_RBYTE;
                     shift_q      <= rd_byte;
                     smb_data_out <= rd_byte[7];
                     smb_data_oe  <= 1'b1;
                  end else begin
                     // Not acknowledged: release and wait for stop.
                     state_q <= ltm_pkg::ST_IDLE;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

endmodule : ltm_mirror

`default_nettype wire

// ==== rtl/ltm_pin_filter.sv ====
// Three-stage synchroniser and agreement filter for asynchronous pins.
`timescale 1ns/10ps
`default_nettype none

module ltm_pin_filter #(
   parameter int WIDTH = 3
) (
   // Clock, reset and enable.
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  wire logic             clk_en,
   // Raw pins and their filtered levels.
   input  wire logic [WIDTH-1:0] pin_raw,
   output var  logic [WIDTH-1:0] pin_filt
);

   if (WIDTH < 1) begin : g_bad_width
      $error("ltm_pin_filter: WIDTH must be at least one");
   end

   // ==========================================================================
   // Per-bit synchroniser
   // ==========================================================================
   for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      logic sync1_q;
      logic sync2_q;
      logic sync3_q;

      // The first stage feeds only the second, so a metastable value never
      // reaches the comparison. The level moves only when stages two and
      // three agree, which also swallows single-sample glitches.
      always_ff @(posedge core_clk or negedge arst_n) begin
         if (!arst_n) begin
            sync1_q     <= 1'b1;
            sync2_q     <= 1'b1;
            sync3_q     <= 1'b1;
            pin_filt[g] <= 1'b1;
         end else if (clk_en) begin
            sync1_q <= pin_raw[g];
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) begin
               pin_filt[g] <= sync3_q;
            end
         end
      end
   end

endmodule : ltm_pin_filter

`default_nettype wire

// ==== rtl/ltm_pkg.sv ====
// Shared constants, field layouts and types of the link test request mirror.
package ltm_pkg;

   // ==========================================================================
   // Management-bus register indexes
   // ==========================================================================
   localparam logic [7:0] IDX_IRQ_VECTOR = 8'h09;
   localparam logic [7:0] IDX_ADJ_LANES01 = 8'h0A;
   localparam logic [7:0] IDX_ADJ_LANES23 = 8'h0B;
   localparam logic [7:0] IDX_TEST_REQUEST = 8'h0C;
   localparam logic [7:0] IDX_TEST_RATE = 8'h0D;
   localparam logic [7:0] IDX_TEST_PARAM_220 = 8'h0E;
   localparam logic [7:0] IDX_COUNT = 8'h14;

   // ==========================================================================
   // Auxiliary channel addresses that the listener mirrors
   // ==========================================================================
   localparam logic [19:0] AUX_CONFIG_REV = 20'h00000;
   localparam logic [19:0] AUX_IRQ_VECTOR = 20'h00201;
   localparam logic [19:0] AUX_ADJ_LANES01 = 20'h00206;
   localparam logic [19:0] AUX_ADJ_LANES23 = 20'h00207;
   localparam logic [19:0] AUX_TEST_REQUEST = 20'h00218;
   localparam logic [19:0] AUX_TEST_RATE = 20'h00219;
   localparam logic [19:0] AUX_TEST_PARAM_220 = 20'h00220;

   // ==========================================================================
   // Field positions, masks, codes and reset values
   // ==========================================================================
   localparam int IRQ_REMOTE_CMD_BIT = 0;
   localparam int IRQ_AUTO_TEST_BIT = 1;
   localparam int IRQ_CONTENT_PROT_BIT = 2;
   localparam int IRQ_MONITOR_CTRL_BIT = 3;
   localparam int IRQ_SINK_SPECIFIC_BIT = 6;
   localparam logic [7:0] IRQ_DEFINED_MASK = 8'h4F;
   localparam int TREQ_LINK_TRAIN_BIT = 0;
   localparam int TREQ_PATTERN_BIT = 1;
   localparam int TREQ_IDENT_READ_BIT = 2;
   localparam int TREQ_PHY_PATTERN_BIT = 3;
   localparam logic [7:0] TREQ_MASK_V10 = 8'h07;
   localparam logic [7:0] TREQ_MASK_V11 = 8'h0F;
   localparam logic [7:0] CONFIG_REV_V11 = 8'h11;
   localparam logic [7:0] RATE_1G62 = 8'h06;
   localparam logic [7:0] RATE_2G70 = 8'h0A;
   localparam logic [7:0] RATE_5G40 = 8'h14;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [6:0] TARGET_ADDR_BASE = 7'h54;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef struct packed {
      logic [1:0] emph;
      logic [1:0] swing;
   } ltm_lane_adj_s;

   typedef struct packed {
      logic        valid;
      logic        src_write;
      logic [19:0] addr;
      logic [7:0]  data;
   } ltm_aux_obs_s;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WBYTE,
      ST_WBYTE_ACK,
      ST_RBYTE,
      ST_RBYTE_ACK
   } ltm_bus_state_e;

endpackage : ltm_pkg

// ==== test/ltm_aux_partner.sv ====
// Behavioural auxiliary source and sink feeding the listener port.
`timescale 1ns/10ps
`default_nettype none

module ltm_aux_partner (
   // Clock and observed traffic.
   input  wire logic                  core_clk,
   output var  ltm_pkg::ltm_aux_obs_s aux_obs
);
   // ========
   // Traffic
   initial aux_obs = '0;

   // One byte per cycle; back to back calls give adjacent bytes.
   task automatic send(input logic w, input logic [19:0] a,
                       input logic [7:0] dat);
      aux_obs = {1'b1, w, a, dat};
      @(posedge core_clk);
      #1;
   endtask : send

   // Fields turn to junk between bytes so stale values cannot pass.
   task automatic idle();
      aux_obs = {1'b0, ~aux_obs[28:0]};
      @(posedge core_clk);
      #1;
   endtask : idle
endmodule : ltm_aux_partner

`default_nettype wire

// ==== test/ltm_mirror_props.sv ====
// Concurrent checks on the ports of the link test request mirror.
`timescale 1ns/10ps
`default_nettype none

module ltm_mirror_props (
   // Clock, reset and enable.
   input wire logic                         core_clk,
   input wire logic                         arst_n,
   input wire logic                         clk_en,
   // Observed auxiliary traffic and bus pins.
   input wire ltm_pkg::ltm_aux_obs_s        aux_obs,
   input wire logic                         smb_clk_pin,
   input wire logic                         smb_data_in,
   input wire logic                         smb_data_out,
   input wire logic                         smb_data_oe,
   input wire logic                         smb_addr_sel,
   // Mirrored state.
   input wire logic [7:0]                   service_irq_vector,
   input wire ltm_pkg::ltm_lane_adj_s [3:0] lane_adj_req,
   input wire logic [7:0]                   sink_test_request,
   input wire logic [7:0]                   test_rate_code,
   input wire logic                         test_rate_known
);
   // ========
   // Helpers
   // A byte only counts while the enable lets the flops move.
   logic        sk;
   logic        sw;
   logic [15:0] lanes;
   logic [19:0] ad;
   logic [7:0]  d;
   assign sk = aux_obs.valid && clk_en && !aux_obs.src_write;
   assign sw = aux_obs.valid && clk_en && aux_obs.src_write;
   assign lanes = lane_adj_req;
   assign ad = aux_obs.addr;
   assign d = aux_obs.data;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   // ========
   // Assertions
   a_vec_sink_copy: assert property (
      sk && ad == 20'h00201 |=> service_irq_vector == ($past(d) & 8'h4F))
      else $error("vector does not follow sink byte");
   a_vec_one_clear: assert property (
      sw && ad == 20'h00201 |=>
      service_irq_vector == ($past(service_irq_vector) & ~$past(d)))
      else $error("vector clear wrong");
   a_vec_resv_zero: assert property (
      (service_irq_vector & 8'hB0) == 8'h00)
      else $error("reserved vector bits set");
   a_lane01_copy: assert property (
      sk && ad == 20'h00206 |=> lanes[7:0] == $past(d))
      else $error("lanes 0 and 1 wrong");
   a_lane23_copy: assert property (
      sk && ad == 20'h00207 |=> lanes[15:8] == $past(d))
      else $error("lanes 2 and 3 wrong");
   a_treq_masked: assert property (
      sk && ad == 20'h00218 |=> sink_test_request == ($past(d) & 8'h07)
      || sink_test_request == ($past(d) & 8'h0F))
      else $error("test request mask wrong");
   a_rate_copy: assert property (
      sk && ad == 20'h00219 |=> test_rate_code == $past(d))
      else $error("rate code wrong");
   a_rate_known: assert property (
      test_rate_known == (test_rate_code inside {8'h06, 8'h0A, 8'h14}))
      else $error("rate known flag wrong");
   a_regs_hold: assert property (
      !(aux_obs.valid && clk_en) |=> $stable(service_irq_vector)
      && $stable(sink_test_request) && $stable(lanes))
      else $error("register moved without traffic");
   a_src_no_lane: assert property (
      sw |=> $stable(lanes) && $stable(test_rate_code))
      else $error("source write moved a read-only register");

   // ========
   // Covers
   c_treq: cover property (sk && ad == 20'h00218);
   c_clear: cover property (sw && ad == 20'h00201);
   c_ack: cover property (smb_data_oe && !smb_data_out);
endmodule : ltm_mirror_props

bind ltm_mirror ltm_mirror_props i_props (.core_clk, .arst_n, .clk_en,
   .aux_obs, .smb_clk_pin, .smb_data_in, .smb_data_out, .smb_data_oe,
   .smb_addr_sel, .service_irq_vector, .lane_adj_req, .sink_test_request,
   .test_rate_code, .test_rate_known);

`default_nettype wire

// ==== test/ltm_mirror_tb_top.sv ====
// Self-checking bench for the link test request mirror.
`timescale 1ns/10ps
`default_nettype none

module ltm_mirror_tb_top;
   // ========
   // Signals
   logic core_clk, arst_n, clk_en, scl, sda_m, sel, sda, oe, dout, known_q;
   logic [7:0] vec, treq, rate, rev;
   logic [7:0] e [9:14];
   logic [19:0] addrs [8] = '{20'h00000, 20'h00201, 20'h00206, 20'h00207,
                              20'h00218, 20'h00219, 20'h00220, 20'h003F0};
   ltm_pkg::ltm_lane_adj_s [3:0] lanes;
   ltm_pkg::ltm_aux_obs_s aux_obs;
   int errors = 0;
   int comparisons = 0;
   int cyc = 0;
   // Open-drain data wire: either party may pull it low.
   assign sda = sda_m & ~(oe & ~dout);

   ltm_aux_partner i_partner (.core_clk(core_clk), .aux_obs(aux_obs));
   ltm_mirror i_dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
      .aux_obs(aux_obs), .smb_clk_pin(scl), .smb_data_in(sda),
      .smb_data_out(dout), .smb_data_oe(oe), .smb_addr_sel(sel),
      .service_irq_vector(vec), .lane_adj_req(lanes),
      .sink_test_request(treq), .test_rate_code(rate),
      .test_rate_known(known_q));

   // ========
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         end_of_test();
      end
   end

   // ========
   // Expectation helpers
   function automatic logic [7:0] tmask(input logic [7:0] v);
      return v & ((rev >= 8'h11) ? 8'h0F : 8'h07);
   endfunction : tmask
   function automatic logic known(input logic [7:0] r);
      return r == 8'h06 || r == 8'h0A || r == 8'h14;
   endfunction : known

   task automatic cmp(input logic [7:0] g, input logic [7:0] x);
      comparisons++;
      if (g !== x) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask : cmp
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wt
   // Sends one byte and moves the expected mirror the same way.
   task automatic aux(input logic w, input logic [19:0] a,
                      input logic [7:0] v);
      i_partner.send(w, a, v);
      if (w && a == 20'h00201) e[9] = e[9] & ~v;
      else if (!w) begin
         case (a)
            20'h00000: rev = v;
            20'h00201: e[9] = v & 8'h4F;
            20'h00206: e[10] = v;
            20'h00207: e[11] = v;
            20'h00218: e[12] = tmask(v);
            20'h00219: e[13] = v;
            20'h00220: e[14] = v;
            default: ;
         endcase
      end
   endtask : aux
   task automatic chk_out();
      i_partner.idle();
      cmp(vec, e[9]);
      cmp(lanes[1:0], e[10]);
      cmp(lanes[3:2], e[11]);
      cmp(treq, e[12]);
      cmp(rate, e[13]);
      cmp({7'h00, known_q}, {7'h00, known(e[13])});
   endtask : chk_out

   // ========
   // Management bus master; every phase lasts ten clocks.
   task automatic pin(input logic c, input logic dv);
      scl = c;
      sda_m = dv;
      wt(10);
   endtask : pin
   task automatic xb(input logic b, output logic r);
      pin(1'b0, b);
      pin(1'b1, b);
      r = sda;
      pin(1'b0, b);
   endtask : xb
   task automatic xbyte(input logic [7:0] v, input logic m,
                        output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) xb(v[i], r[i]);
      xb(m, a);
   endtask : xbyte
   task automatic start();
      pin(1'b0, 1'b1);
      pin(1'b1, 1'b1);
      pin(1'b1, 1'b0);
      pin(1'b0, 1'b0);
   endtask : start
   task automatic stop();
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b0);
      pin(1'b1, 1'b1);
   endtask : stop
   task automatic rd(input logic [7:0] ad, input logic [7:0] ix, input int n);
      logic [7:0] r;
      logic a;
      start();
      xbyte(ad, 1'b1, r, a);
      cmp({7'h00, a}, 8'h00);
      xbyte(ix, 1'b1, r, a);
      start();
      xbyte(ad | 8'h01, 1'b1, r, a);
      xbyte(8'hFF, 1'b0, r, a);
      cmp(r, 8'h14 - ix);
      for (int k = 0; k < n; k++) begin
         xbyte(8'hFF, k == n - 1, r, a);
         cmp(r, e[ix + k]);
      end
      stop();
   endtask : rd

   task end_of_test();
      $display("counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   // ========
   // Main sequence
   initial begin
      logic [7:0] r;
      logic a;
      static logic [7:0] wseq [5] = '{8'hA8, 8'h0C, 8'h02, 8'hAA, 8'h55};
      static logic [7:0] rates [4] = '{8'h06, 8'h0A, 8'h14, 8'h15};
      arst_n = 1'b0;
      clk_en = 1'b1;
      scl = 1'b1;
      sda_m = 1'b1;
      sel = 1'b0;
      rev = 8'h00;
      foreach (e[i]) e[i] = 8'h00;
      void'($urandom(82));
      wt(8);
      arst_n = 1'b1;
      wt(4);
      chk_out();
      $display("reset test done");
      for (int i = 0; i < 60; i++) begin
         aux(8'($urandom) < 8'h40, addrs[$urandom % 8], 8'($urandom));
         if (i % 5 == 4) chk_out();
      end
      $display("random traffic test done");
      aux(1'b0, 20'h00000, 8'h11);
      aux(1'b0, 20'h00201, 8'hFF);
      aux(1'b1, 20'h00201, 8'h02);
      aux(1'b1, 20'h003F0, 8'hC3);
      aux(1'b0, 20'h00218, 8'hFF);
      aux(1'b0, 20'h00220, 8'h5A);
      chk_out();
      aux(1'b0, 20'h00000, 8'h10);
      aux(1'b0, 20'h00218, 8'hFF);
      chk_out();
      foreach (rates[i]) begin
         aux(1'b0, 20'h00219, rates[i]);
         chk_out();
      end
      clk_en = 1'b0;
      i_partner.send(1'b0, 20'h00219, 8'h0A);
      clk_en = 1'b1;
      chk_out();
      $display("corner test done");
      rd(8'hA8, 8'h09, 6);
      sel = 1'b1;
      wt(8);
      rd(8'hAA, 8'h0C, 3);
      start();
      xbyte(8'hA8, 1'b1, r, a);
      cmp({7'h00, a}, 8'h01);
      stop();
      wseq[0] = 8'hAA;
      start();
      foreach (wseq[i]) begin
         xbyte(wseq[i], 1'b1, r, a);
         cmp({7'h00, a}, 8'h00);
      end
      stop();
      chk_out();
      $display("bus test done");
      end_of_test();
   end
endmodule : ltm_mirror_tb_top

`default_nettype wire
